/* core/nvc_control.sv */
// Notes on behaviour
// - Closed-loop settle code picks 150/300/500/2000 us.
// - VCO settle code picks 20/400/4000/10000 us.
// - Stored CRC byte readable, fetched from memory.
// - Count increments after each erase/program cycle.
// - Count saturates at 255, never wraps.
// - Count reloads after reset, load bit, cycle.
// - Register copy bit copies registers, self-clears.
// - CRC mismatch on load sets error flag.
// - Auto-CRC on computes stored CRC when programming.
// - Memory loads registers at reset or load bit.
// - Register reads refused while memory load runs.
// - Busy flag high throughout erase/program cycle.
// - Erase/program needs unlock in preceding transaction.
// - Program bit starts long program cycle, self-clears.
// - Both bits together run erase then program.
// - Loop-filter C3 field: 3 bits, RW, reset 0.
`timescale 1ns/1ps
`include "nvc_defines.svh"

module nvc_control
  import nvc_pkg::*;
#(
  parameter logic [7:0] UNLOCK_CODE = 8'hA5, // Arbitrary value.
  parameter int unsigned CLW0_CYC = `NVC_CLW0_US * `NVC_MCLK_MHZ,
  parameter int unsigned CLW1_CYC = `NVC_CLW1_US * `NVC_MCLK_MHZ,
  parameter int unsigned CLW2_CYC = `NVC_CLW2_US * `NVC_MCLK_MHZ,
  parameter int unsigned CLW3_CYC = `NVC_CLW3_US * `NVC_MCLK_MHZ,
  parameter int unsigned VCW0_CYC = `NVC_VCW0_US * `NVC_MCLK_MHZ,
  parameter int unsigned VCW1_CYC = `NVC_VCW1_US * `NVC_MCLK_MHZ,
  parameter int unsigned VCW2_CYC = `NVC_VCW2_US * `NVC_MCLK_MHZ,
  parameter int unsigned VCW3_CYC = `NVC_VCW3_US * `NVC_MCLK_MHZ,
  parameter int unsigned NV_CYCLE_CYC = `NVC_NV_CYCLE_US * `NVC_MCLK_MHZ
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire nvc_req_type req,
  input wire logic xact_end,
  output nvc_resp_type resp,
  output logic [2:0] loop_filter_third_cap,
  output logic [1:0] closed_loop_settle_code,
  output logic [1:0] vco_settle_code,
  output logic [31:0] closed_loop_wait_cycles,
  output logic [31:0] vco_wait_cycles,
  output logic rom_busy_flag
);

  // CRC-8, polynomial x^8+x^2+x+1, over the two configuration bytes.
  function automatic logic [7:0] nvc_crc8(input logic [7:0] b0, input logic [7:0] b1);
    logic [7:0] c;
    logic [15:0] s;
    c = 8'h00;
    s = {b0, b1};
    for (int i = 15; i >= 0; i--) begin
      if (c[7] ^ s[i]) begin
        c = {c[6:0], 1'b0} ^ 8'h07;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CAL_RST = {4'h0, `NVC_CLSD_RST, `NVC_VCO_RST};
  localparam logic [7:0] LFC3_RST = {5'h00, `NVC_LF_C3_RST};
  localparam logic [7:0] IMG_CRC = nvc_crc8(LFC3_RST, CAL_RST);

  nvc_state_type state_q, state_d;
  logic [7:0] nv_q [4];
  logic [7:0] nv_d [4];
  logic [7:0] sram_q [4];
  logic [7:0] sram_d [4];
  logic [1:0] idx_q, idx_d;
  logic [31:0] timer_q, timer_d;
  logic op_erase_q, op_erase_d;
  logic op_prog_q, op_prog_d;
  logic [2:0] lfc3_q, lfc3_d;
  logic [1:0] clsd_q, clsd_d;
  logic [1:0] vco_q, vco_d;
  logic [7:0] scrc_q, scrc_d;
  logic [7:0] cnt_q, cnt_d;
  logic crc_fail_q, crc_fail_d;
  logic auto_crc_q, auto_crc_d;
  logic xact_ok_q, xact_ok_d;
  logic xact_bad_q, xact_bad_d;
  logic armed_q, armed_d;
  nvc_resp_type resp_q, resp_d;
  logic busy_q, busy_d;
  logic [31:0] clw_q, clw_d;
  logic [31:0] vcw_q, vcw_d;
  logic [7:0] ctl_rd;
  logic [7:0] next_cnt;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctl_rd = 8'h00;
    ctl_rd[`NVC_CTL_REGCOPY] = (state_q == ST_COPY);
    ctl_rd[`NVC_CTL_CRCFAIL] = crc_fail_q;
    ctl_rd[`NVC_CTL_AUTOCRC] = auto_crc_q;
    ctl_rd[`NVC_CTL_BUSY] = (state_q == ST_CYCLE);
    ctl_rd[`NVC_CTL_ERASE] = (state_q == ST_CYCLE) && op_erase_q;
    ctl_rd[`NVC_CTL_PROG] = (state_q == ST_CYCLE) && op_prog_q;
    next_cnt = (nv_q[`NVC_W_CNT] == `NVC_CNT_MAX) ? `NVC_CNT_MAX :
               nv_q[`NVC_W_CNT] + 8'h01;
  end

  always_comb begin
    state_d = state_q;
    nv_d = nv_q;
    sram_d = sram_q;
    idx_d = idx_q;
    timer_d = timer_q;
    op_erase_d = op_erase_q;
    op_prog_d = op_prog_q;
    lfc3_d = lfc3_q;
    clsd_d = clsd_q;
    vco_d = vco_q;
    scrc_d = scrc_q;
    cnt_d = cnt_q;
    crc_fail_d = crc_fail_q;
    auto_crc_d = auto_crc_q;
    xact_ok_d = xact_ok_q;
    xact_bad_d = xact_bad_q;
    armed_d = armed_q;
    resp_d = '0;

    // Unlock is honoured only for the transaction right after the unlocking one.
    if (req.wr) begin
      if (req.addr == `NVC_ADDR_UNLOCK && req.wdata == UNLOCK_CODE) begin
        xact_ok_d = 1'b1;
      end else begin
        xact_bad_d = 1'b1;
      end
    end
    if (req.rd) begin
      xact_bad_d = 1'b1;
    end
    if (xact_end) begin
      armed_d = xact_ok_d && !xact_bad_d;
      xact_ok_d = 1'b0;
      xact_bad_d = 1'b0;
    end

    if (req.rd) begin
      resp_d.ack = 1'b1;
      if (state_q == ST_LOAD) begin
        resp_d.refused = 1'b1;
      end else begin
        case (req.addr)
          `NVC_ADDR_LF_C3: resp_d.data = {5'h00, lfc3_q};
          `NVC_ADDR_CAL: resp_d.data = {4'h0, clsd_q, vco_q};
          `NVC_ADDR_SCRC: resp_d.data = scrc_q;
          `NVC_ADDR_CNT: resp_d.data = cnt_q;
          `NVC_ADDR_CTL: resp_d.data = ctl_rd;
          default: resp_d.data = 8'h00;
        endcase
      end
    end

    if (req.wr && state_q != ST_LOAD) begin
      case (req.addr)
        `NVC_ADDR_LF_C3: lfc3_d = req.wdata[2:0];
        `NVC_ADDR_CAL: begin
          clsd_d = req.wdata[`NVC_CAL_CLSD_LSB +: 2];
          vco_d = req.wdata[`NVC_CAL_VCO_LSB +: 2];
        end
        `NVC_ADDR_CTL: begin
          auto_crc_d = req.wdata[`NVC_CTL_AUTOCRC];
          // Outside idle the start bits fall on the floor.
          if (state_q == ST_IDLE) begin
            if (req.wdata[`NVC_CTL_REGCOPY]) begin
              state_d = ST_COPY;
            end else if (req.wdata[`NVC_CTL_LOAD]) begin
              state_d = ST_LOAD;
              idx_d = 2'h0;
            end else if ((req.wdata[`NVC_CTL_ERASE] || req.wdata[`NVC_CTL_PROG]) &&
                         armed_q) begin
              state_d = ST_CYCLE;
              op_erase_d = req.wdata[`NVC_CTL_ERASE];
              op_prog_d = req.wdata[`NVC_CTL_PROG];
              timer_d = 32'h0000_0000;
            end
          end
        end
        default: ;
      endcase
    end

    case (state_q)
      ST_LOAD: begin
        sram_d[idx_q] = nv_q[idx_q];
        case (idx_q)
          `NVC_W_LFC3: lfc3_d = nv_q[idx_q][2:0];
          `NVC_W_CAL: begin
            clsd_d = nv_q[idx_q][`NVC_CAL_CLSD_LSB +: 2];
            vco_d = nv_q[idx_q][`NVC_CAL_VCO_LSB +: 2];
          end
          `NVC_W_CNT: cnt_d = nv_q[idx_q];
          default: begin
            scrc_d = nv_q[idx_q];
            crc_fail_d = (nv_q[idx_q] != nvc_crc8(nv_q[`NVC_W_LFC3], nv_q[`NVC_W_CAL]));
            state_d = ST_IDLE;
          end
        endcase
        idx_d = idx_q + 2'h1;
      end
      ST_COPY: begin
        sram_d[`NVC_W_LFC3] = {5'h00, lfc3_q};
        sram_d[`NVC_W_CAL] = {4'h0, clsd_q, vco_q};
        state_d = ST_IDLE;
      end
      ST_CYCLE: begin
        // The cycle runs its full length no matter what the host writes.
        if (timer_q >= NV_CYCLE_CYC - 1) begin
          timer_d = 32'h0000_0000;
          if (op_erase_q) begin
            nv_d[`NVC_W_LFC3] = 8'h00;
            nv_d[`NVC_W_CAL] = 8'h00;
            nv_d[`NVC_W_CRC] = 8'h00;
            op_erase_d = 1'b0;
          end else begin
            nv_d[`NVC_W_LFC3] = sram_q[`NVC_W_LFC3];
            nv_d[`NVC_W_CAL] = sram_q[`NVC_W_CAL];
            nv_d[`NVC_W_CRC] = auto_crc_q ?
                nvc_crc8(sram_q[`NVC_W_LFC3], sram_q[`NVC_W_CAL]) : sram_q[`NVC_W_CRC];
            op_prog_d = 1'b0;
          end
          // Erase phase flows into the program phase when both were asked.
          if (!(op_erase_q && op_prog_q)) begin
            nv_d[`NVC_W_CNT] = next_cnt;
            cnt_d = next_cnt;
            state_d = ST_IDLE;
          end
        end else begin
          timer_d = timer_q + 32'h0000_0001;
        end
      end
      default: ;
    endcase

    busy_d = (state_d == ST_CYCLE);
    case (clsd_d)
      2'h0: clw_d = CLW0_CYC;
      2'h1: clw_d = CLW1_CYC;
      2'h2: clw_d = CLW2_CYC;
      default: clw_d = CLW3_CYC;
    endcase
    case (vco_d)
      2'h0: vcw_d = VCW0_CYC;
      2'h1: vcw_d = VCW1_CYC;
      2'h2: vcw_d = VCW2_CYC;
      default: vcw_d = VCW3_CYC;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset stands in for power-on: the memory image returns to its factory content.
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_LOAD;
      nv_q <= '{LFC3_RST, CAL_RST, 8'h00, IMG_CRC};
      sram_q <= '{LFC3_RST, CAL_RST, 8'h00, IMG_CRC};
      idx_q <= 2'h0;
      timer_q <= 32'h0000_0000;
      op_erase_q <= 1'b0;
      op_prog_q <= 1'b0;
      lfc3_q <= `NVC_LF_C3_RST;
      clsd_q <= `NVC_CLSD_RST;
      vco_q <= `NVC_VCO_RST;
      scrc_q <= 8'h00;
      cnt_q <= 8'h00;
      crc_fail_q <= 1'b0;
      auto_crc_q <= `NVC_AUTOCRC_RST;
      xact_ok_q <= 1'b0;
      xact_bad_q <= 1'b0;
      armed_q <= 1'b0;
      resp_q <= '0;
      busy_q <= 1'b0;
      clw_q <= CLW2_CYC;
      vcw_q <= VCW1_CYC;
    end else if (ce) begin
      state_q <= state_d;
      nv_q <= nv_d;
      sram_q <= sram_d;
      idx_q <= idx_d;
      timer_q <= timer_d;
      op_erase_q <= op_erase_d;
      op_prog_q <= op_prog_d;
      lfc3_q <= lfc3_d;
      clsd_q <= clsd_d;
      vco_q <= vco_d;
      scrc_q <= scrc_d;
      cnt_q <= cnt_d;
      crc_fail_q <= crc_fail_d;
      auto_crc_q <= auto_crc_d;
      xact_ok_q <= xact_ok_d;
      xact_bad_q <= xact_bad_d;
      armed_q <= armed_d;
      resp_q <= resp_d;
      busy_q <= busy_d;
      clw_q <= clw_d;
      vcw_q <= vcw_d;
    end
  end

  assign resp = resp_q;
  assign loop_filter_third_cap = lfc3_q;
  assign closed_loop_settle_code = clsd_q;
  assign vco_settle_code = vco_q;
  assign closed_loop_wait_cycles = clw_q;
  assign vco_wait_cycles = vcw_q;
  assign rom_busy_flag = busy_q;

endmodule // nvc_control

/* core/nvc_defines.svh */
`ifndef NVC_DEFINES_SVH
`define NVC_DEFINES_SVH

// Register addresses on the serial register port.
`define NVC_ADDR_LF_C3 8'h27
`define NVC_ADDR_CAL 8'h2A
`define NVC_ADDR_SCRC 8'h2F
`define NVC_ADDR_CNT 8'h30
`define NVC_ADDR_CTL 8'h31
`define NVC_ADDR_UNLOCK 8'h61

// Control register bit positions.
`define NVC_CTL_REGCOPY 6
`define NVC_CTL_CRCFAIL 5
`define NVC_CTL_AUTOCRC 4
`define NVC_CTL_LOAD 3
`define NVC_CTL_BUSY 2
`define NVC_CTL_ERASE 1
`define NVC_CTL_PROG 0

// Calibration wait register fields.
`define NVC_CAL_CLSD_LSB 2
`define NVC_CAL_VCO_LSB 0

// Reset values, and the count ceiling.
`define NVC_CLSD_RST 2'h2
`define NVC_VCO_RST 2'h1
`define NVC_LF_C3_RST 3'h0
`define NVC_AUTOCRC_RST 1'b1
`define NVC_CNT_MAX 8'hFF

// Word positions inside the nonvolatile image.
`define NVC_W_LFC3 2'h0
`define NVC_W_CAL 2'h1
`define NVC_W_CNT 2'h2
`define NVC_W_CRC 2'h3

// Timing, in microseconds, and the clock rate.
`define NVC_MCLK_MHZ 250
`define NVC_CLW0_US 150
`define NVC_CLW1_US 300
`define NVC_CLW2_US 500
`define NVC_CLW3_US 2000
`define NVC_VCW0_US 20
`define NVC_VCW1_US 400
`define NVC_VCW2_US 4000
`define NVC_VCW3_US 10000
`define NVC_NV_CYCLE_US 115000

`endif

/* core/nvc_pkg.sv */
package nvc_pkg;

  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_IDLE = 2'b01,
    ST_COPY = 2'b10,
    ST_CYCLE = 2'b11
  } nvc_state_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } nvc_req_type;

  typedef struct packed {
    logic ack;
    logic refused;
    logic [7:0] data;
  } nvc_resp_type;

endpackage

/* verif/nvc_control_monitor.sv */
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_control_monitor
  import nvc_pkg::*;
#(
  parameter int unsigned NV_CYCLE_CYC = 20
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic ce,
  input wire nvc_req_type req,
  input wire logic xact_end,
  input wire nvc_resp_type resp,
  input wire logic [2:0] loop_filter_third_cap,
  input wire logic [1:0] closed_loop_settle_code,
  input wire logic [1:0] vco_settle_code,
  input wire logic [31:0] closed_loop_wait_cycles,
  input wire logic [31:0] vco_wait_cycles,
  input wire logic rom_busy_flag
);
  logic [31:0] busy_n_q;
  logic [31:0] busy_n_d;
  // The stretch length is read at the falling edge, so one phase or two both pass.
  always_comb begin
    busy_n_d = rom_busy_flag ? busy_n_q + 32'h1 : 32'h0;
  end
  always_ff @(posedge mclk) begin
    busy_n_q <= srst ? 32'h0 : busy_n_d;
  end
  ////////////////////////////////////////
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);
  property p_ack; req.rd && ce |=> resp.ack; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  property p_ackone; resp.ack |-> $past(req.rd && ce); endproperty
  a_ackone: assert property (p_ackone) else $error("answer without read");
  property p_idle; !resp.ack |-> resp.data == 8'h00 && !resp.refused; endproperty
  a_idle: assert property (p_idle) else $error("response not quiet");
  property p_ref; resp.refused |-> resp.data == 8'h00; endproperty
  a_ref: assert property (p_ref) else $error("refused read carries data");
  property p_lref; $past(srst) && req.rd |=> resp.refused; endproperty
  a_lref: assert property (p_lref) else $error("read served during load");
  property p_rst;
    $past(srst) |-> loop_filter_third_cap == 3'h0 && closed_loop_settle_code == 2'h2
      && vco_settle_code == 2'h1 && !rom_busy_flag;
  endproperty
  a_rst: assert property (p_rst) else $error("bad value after reset");
  property p_blen;
    $fell(rom_busy_flag) |-> busy_n_q == NV_CYCLE_CYC || busy_n_q == 2 * NV_CYCLE_CYC;
  endproperty
  a_blen: assert property (p_blen) else $error("busy length wrong");
  property p_bstart;
    $rose(rom_busy_flag) |->
      $past(req.wr && req.addr == `NVC_ADDR_CTL && req.wdata[1:0] != 2'h0);
  endproperty
  a_bstart: assert property (p_bstart) else $error("busy without start");
endmodule // nvc_control_monitor

bind nvc_control nvc_control_monitor #(.NV_CYCLE_CYC(NV_CYCLE_CYC)) u_mon (.mclk(mclk),
  .srst(srst), .ce(ce), .req(req), .xact_end(xact_end), .resp(resp),
  .loop_filter_third_cap(loop_filter_third_cap),
  .closed_loop_settle_code(closed_loop_settle_code), .vco_settle_code(vco_settle_code),
  .closed_loop_wait_cycles(closed_loop_wait_cycles), .vco_wait_cycles(vco_wait_cycles),
  .rom_busy_flag(rom_busy_flag));

/* verif/nvc_host_model.sv */
`timescale 1ns/1ps
`include "nvc_defines.svh"
module nvc_host_model
  import nvc_pkg::*;
#(
  parameter logic [7:0] UNLOCK_CODE = 8'hA5 // Arbitrary value.
) (
  input wire logic mclk,
  output nvc_req_type req,
  output logic xact_end,
  input wire nvc_resp_type resp
);
  initial begin
    req = '0;
    xact_end = 1'b0;
  end
  ////////////////////////////////////////
  // Released lines show the inverse so a stale address is never mistaken for a live one.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
    req.addr <= ~a;
    req.wdata <= ~d;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic r);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    req.addr <= ~a;
    @(posedge mclk);
    d = resp.data;
    r = resp.refused;
  endtask
  task automatic stop();
    xact_end <= 1'b1;
    @(posedge mclk);
    xact_end <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic unlock();
    wr(`NVC_ADDR_UNLOCK, UNLOCK_CODE);
    stop();
  endtask
  task automatic idle(output logic ok);
    logic [7:0] d;
    logic r;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++) begin
      rd(`NVC_ADDR_CTL, d, r);
      ok = (d[`NVC_CTL_BUSY] === 1'b0) && (r === 1'b0);
    end
  endtask
endmodule // nvc_host_model

/* verif/nvc_control_tb_top.sv */
`timescale 1ns/1ps
module nvc_control_tb_top
  import nvc_pkg::*;
;
  localparam int unsigned NV = 20;
  localparam logic [31:0] CW [4] = '{32'h11, 32'h12, 32'h13, 32'h14};
  localparam logic [31:0] VW [4] = '{32'h21, 32'h22, 32'h23, 32'h24};
  localparam logic [7:0] RA [6] = '{8'h27, 8'h2A, 8'h2F, 8'h30, 8'h31, 8'h40};
  localparam logic [7:0] RV [6] = '{8'h00, 8'h09, 8'h3F, 8'h00, 8'h10, 8'h00};
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic xact_end;
  logic busy;
  logic ok;
  logic [7:0] rd_data;
  logic rd_refused;
  logic [2:0] lfc3;
  logic [1:0] clc;
  logic [1:0] vcc;
  logic [31:0] clw;
  logic [31:0] vcw;
  nvc_req_type req;
  nvc_resp_type resp;
  int n_errors = 0;
  int check_count = 0;
  always #2 mclk = ~mclk;
  nvc_control #(.NV_CYCLE_CYC(NV), .CLW0_CYC(CW[0]), .CLW1_CYC(CW[1]), .CLW2_CYC(CW[2]),
    .CLW3_CYC(CW[3]), .VCW0_CYC(VW[0]), .VCW1_CYC(VW[1]), .VCW2_CYC(VW[2]),
    .VCW3_CYC(VW[3])) dut (.mclk(mclk), .srst(srst), .ce(ce), .req(req),
    .xact_end(xact_end), .resp(resp), .loop_filter_third_cap(lfc3),
    .closed_loop_settle_code(clc), .vco_settle_code(vcc), .closed_loop_wait_cycles(clw),
    .vco_wait_cycles(vcw), .rom_busy_flag(busy));
  nvc_host_model h (.mclk(mclk), .req(req), .xact_end(xact_end), .resp(resp));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got 0x%0h exp 0x%0h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic r;
    h.rd(a, d, r);
    chk({24'h0, d}, {24'h0, e});
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // The run needs about 32 us; six times that leaves room without hiding a hang.
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    rc(8'h2A, 8'h00);
    h.rd(8'h30, rd_data, rd_refused);
    chk({31'h0, rd_refused}, 32'h1);
    repeat (4) @(posedge mclk);
    foreach (RA[i]) begin
      rc(RA[i], RV[i]);
    end
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      h.wr(8'h2A, 8'(3 * i + 3));
      @(posedge mclk);
      chk({28'h0, clc, vcc}, 32'(3 * i + 3));
      chk(clw, CW[i]);
      chk(vcw, VW[3 - i]);
    end
    h.wr(8'h27, 8'hFF);
    h.wr(8'h2F, 8'h55);
    h.wr(8'h30, 8'h55);
    rc(8'h27, 8'h07);
    chk({29'h0, lfc3}, 32'h7);
    rc(8'h2F, 8'h3F);
    rc(8'h30, 8'h00);
    $display("test fields done");
    // A write made while the clock enable is low must leave the field as it was.
    ce <= 1'b0;
    h.wr(8'h27, 8'h03);
    ce <= 1'b1;
    rc(8'h27, 8'h07);
    h.wr(8'h27, 8'h05);
    h.wr(8'h2A, 8'h06);
    h.wr(8'h31, 8'h11);
    h.stop();
    chk({31'h0, busy}, 32'h0);
    h.wr(8'h61, 8'h5A);
    h.stop();
    h.wr(8'h31, 8'h11);
    h.stop();
    chk({31'h0, busy}, 32'h0);
    h.unlock();
    h.wr(8'h27, 8'h05);
    h.stop();
    h.wr(8'h31, 8'h11);
    h.stop();
    chk({31'h0, busy}, 32'h0);
    h.wr(8'h31, 8'h50);
    rc(8'h31, 8'h10);
    h.stop();
    h.unlock();
    h.wr(8'h31, 8'h13);
    chk({31'h0, busy}, 32'h1);
    h.wr(8'h27, 8'h01);
    h.wr(8'h31, 8'h58);
    h.stop();
    h.idle(ok);
    chk({31'h0, ok}, 32'h1);
    rc(8'h30, 8'h01);
    rc(8'h27, 8'h01);
    h.wr(8'h31, 8'h18);
    repeat (6) @(posedge mclk);
    rc(8'h27, 8'h05);
    rc(8'h2A, 8'h06);
    rc(8'h2F, 8'h53);
    rc(8'h31, 8'h10);
    $display("test program done");
    h.wr(8'h31, 8'h00);
    h.wr(8'h27, 8'h02);
    h.wr(8'h31, 8'h40);
    h.stop();
    h.unlock();
    h.wr(8'h31, 8'h01);
    h.stop();
    h.idle(ok);
    chk({31'h0, ok}, 32'h1);
    h.wr(8'h31, 8'h08);
    repeat (6) @(posedge mclk);
    rc(8'h31, 8'h20);
    $display("test crc done");
    for (int i = 0; i < 260; i++) begin
      // Close the polling reads first, or they would spoil the unlock transaction.
      h.stop();
      h.unlock();
      h.wr(8'h31, 8'h02);
      h.stop();
      h.idle(ok);
      chk({31'h0, ok}, 32'h1);
    end
    h.wr(8'h31, 8'h08);
    repeat (6) @(posedge mclk);
    rc(8'h27, 8'h00);
    rc(8'h30, 8'hFF);
    $display("test count done");
    end_sim();
  end
endmodule // nvc_control_tb_top
